// >>> hdl/oag_index_calc.sv
/*
 * Index address and update arithmetic, combinational.
 * Assumes the caller registers both results.
 */
`timescale 1ns/1ns
module oag_index_calc #(
    parameter int IDX_W = 16
) (
    // index value and access mode
    input wire logic [IDX_W-1:0] base,
    input wire oag_pkg::oag_imode_t mode,
    // relative offset, unsigned
    input wire logic [7:0] offset,
    input wire logic offset_en,
    // results
    output logic [IDX_W-1:0] addr,
    output logic [IDX_W-1:0] next
);

    logic [IDX_W-1:0] inc_val;
    logic [IDX_W-1:0] dec_val;
    logic [IDX_W-1:0] rel_val;

    // wrapping step and zero-extended offset sums, carry out dropped
    assign inc_val = IDX_W'(base + IDX_W'(oag_pkg::OAG_IDX_STEP)); // see [RL16]
    assign dec_val = IDX_W'(base - IDX_W'(oag_pkg::OAG_IDX_STEP)); // see [RL16]
    assign rel_val = IDX_W'(base + {{(IDX_W-8){1'b0}}, offset}); // see [RL17]

    // pick access address and written-back value
    always_comb
    begin
        addr = base;
        next = base;
        if (offset_en)
        begin
            addr = rel_val; // see [RL6] see [RL7]
        end
        else
        begin
            case (mode)
                oag_pkg::OAG_IM_KEEP: next = base;
                oag_pkg::OAG_IM_POST_DEC: next = dec_val;
                oag_pkg::OAG_IM_POST_INC: next = inc_val;
                oag_pkg::OAG_IM_PRE_INC:
                begin
                    addr = inc_val; // see [RL16]
                    next = inc_val;
                end
                default: next = base;
            endcase
        end
    end

endmodule

// >>> hdl/oag_pkg.sv
/*
 * Constants, enums and carrier structs of the operand address block.
 * Assumes one core clock and a decoder that fills oag_req_t.
 */
package oag_pkg;

    // widths
    localparam int OAG_IDX_W = 16;
    localparam int OAG_DATA_W = 8;
    localparam int OAG_REG_AW = 5;
    localparam int OAG_PAIRS = 4;

    // index register reset value and step
    localparam logic [15:0] OAG_IDX_RST = 16'h0000;
    localparam logic [15:0] OAG_IDX_STEP = 16'h0001;

    // general register numbers that hold the index pairs, low byte even
    localparam logic [4:0] OAG_IDX_REG_BASE = 5'h0C;
    localparam logic [4:0] OAG_IDX_REG_LAST = 5'h13;

    // last register that a limited operand field may name
    localparam logic [4:0] OAG_LIMITED_LAST = 5'h0F;

    // pair used by the immediate-relative mode
    localparam logic [1:0] OAG_IMM_REL_PAIR = 2'h3;

    // instruction classes seen by this block
    typedef enum logic [2:0] {
        OAG_OP_MOVE = 3'b000,
        OAG_OP_ADD = 3'b001,
        OAG_OP_SUB = 3'b010,
        OAG_OP_LONG_JUMP = 3'b011,
        OAG_OP_OTHER = 3'b100
    } oag_op_t;

    // operand addressing modes
    typedef enum logic [2:0] {
        OAG_AM_REG = 3'b000,
        OAG_AM_IMM = 3'b001,
        OAG_AM_INDEXED = 3'b010,
        OAG_AM_IMM_REL = 3'b011,
        OAG_AM_REG_REL = 3'b100
    } oag_amode_t;

    // index register update modes
    typedef enum logic [1:0] {
        OAG_IM_KEEP = 2'b00,
        OAG_IM_POST_DEC = 2'b01,
        OAG_IM_POST_INC = 2'b10,
        OAG_IM_PRE_INC = 2'b11
    } oag_imode_t;

    // byte transfer kinds
    typedef enum logic [2:0] {
        OAG_XF_NONE = 3'b000,
        OAG_XF_REG_REG = 3'b001,
        OAG_XF_MEM_REG = 3'b010,
        OAG_XF_REG_MEM = 3'b011,
        OAG_XF_IMEM_REG = 3'b100,
        OAG_XF_IMEM_MEM = 3'b101,
        OAG_XF_JUMP = 3'b110
    } oag_xfer_t;

    // arithmetic function
    typedef enum logic [1:0] {
        OAG_ALU_NONE = 2'b00,
        OAG_ALU_ADD = 2'b01,
        OAG_ALU_SUB = 2'b10
    } oag_alu_t;

    // arithmetic operand form
    typedef enum logic [1:0] {
        OAG_FORM_NONE = 2'b00,
        OAG_FORM_ACC = 2'b01,
        OAG_FORM_ACC_CARRY = 2'b10,
        OAG_FORM_IMM = 2'b11
    } oag_form_t;

    // decoded instruction presented to the block
    typedef struct packed {
        logic valid;
        oag_op_t op;
        oag_amode_t src_mode;
        oag_amode_t dst_mode;
        logic [1:0] idx_sel;
        oag_imode_t idx_mode;
        logic [7:0] imm;
        logic [4:0] src_reg;
        logic [4:0] dst_reg;
        logic with_carry;
    } oag_req_t;

    // operand plan returned one cycle later
    typedef struct packed {
        logic valid;
        logic illegal;
        oag_xfer_t xfer;
        oag_alu_t alu;
        oag_form_t form;
        logic dmem_en;
        logic [15:0] dmem_addr;
        logic imem_en;
        logic [15:0] imem_addr;
        logic [7:0] operand_b;
        logic [4:0] src_reg;
        logic [4:0] dst_reg;
        logic dst_mem;
    } oag_resp_t;

    // byte write into the general register file
    typedef struct packed {
        logic en;
        logic [4:0] addr;
        logic [7:0] data;
    } oag_gr_wr_t;

endpackage

// >>> hdl/oag_top.sv
/*
 * Operand address generation: the four index pairs,
 * operand form checks for move, add, subtract and long jump,
 * and a registered operand plan.
 * Assumes at most one decoded request per cycle and that
 * writes to registers 12..19 arrive through the general
 * register write port.
 */
`timescale 1ns/1ns

// Summary of operation
// [RL1] four 16-bit index registers, each two 8-bit general registers
// [RL2] pairs 13/12, 15/14, 17/16, 19/18; higher register is upper byte
// [RL3] reset clears all index registers
// [RL4] indexed modes: keep, post-decrement, post-increment, pre-increment
// [RL5] index is a data byte address; long jump takes it as word address
// [RL6] immediate-relative: fourth index plus unsigned immediate
// [RL7] register-relative: chosen index plus unsigned accumulator
// [RL8] relative modes only on move
// [RL9] move carries one byte in one of five transfer kinds
// [RL10] immediate move to limited register or index-addressed memory; the memory form is accepted only with keep mode
// [RL11] add, subtract: accumulator, accumulator with carry, immediate
// [RL12] accumulator forms take a separate register or indexed destination
// [RL13] active alternate bank picks the accumulator
// [RL14] immediate arithmetic: one limited register is source and destination
// [RL15] limited fields reach registers 0..15, full fields 0..31
// [RL16] pre-increment uses new value, post modes old; wrap at 65536
// [RL17] relative sums cut to 16 bits
module oag_top #(
    parameter int IDX_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // decoded instruction
    input wire oag_pkg::oag_req_t req,
    // accumulators of both banks and the active bank
    input wire logic [7:0] acc_main,
    input wire logic [7:0] acc_alt,
    input wire logic alt_bank_active,
    // general register byte writes
    input wire oag_pkg::oag_gr_wr_t gr_wr,
    // operand plan
    output oag_pkg::oag_resp_t resp,
    // index register contents
    output logic [IDX_W-1:0] index_pair_0,
    output logic [IDX_W-1:0] index_pair_1,
    output logic [IDX_W-1:0] index_pair_2,
    output logic [IDX_W-1:0] index_pair_3
);

    logic [IDX_W-1:0] index_r [oag_pkg::OAG_PAIRS];
    logic [IDX_W-1:0] index_nxt [oag_pkg::OAG_PAIRS];
    oag_pkg::oag_resp_t resp_r;
    oag_pkg::oag_resp_t resp_nxt;

    logic [7:0] acc_sel;
    logic [1:0] pair_sel;
    logic [IDX_W-1:0] pair_base;
    logic [7:0] rel_offset;
    logic rel_en;
    oag_pkg::oag_imode_t calc_mode;
    logic [IDX_W-1:0] calc_addr;
    logic [IDX_W-1:0] calc_next;
    logic src_ix;
    logic dst_ix;
    logic src_rel;
    logic dst_rel;
    logic src_mem;
    logic dst_mem;
    logic legal;
    logic upd_en;
    logic [4:0] wr_off;

    // implied accumulator follows the active alternate bank
    assign acc_sel = alt_bank_active ? acc_alt : acc_main; // see [RL13]

    // operand classification
    assign src_ix = (req.src_mode == oag_pkg::OAG_AM_INDEXED);
    assign dst_ix = (req.dst_mode == oag_pkg::OAG_AM_INDEXED);
    assign src_rel = (req.src_mode == oag_pkg::OAG_AM_IMM_REL)
        || (req.src_mode == oag_pkg::OAG_AM_REG_REL);
    assign dst_rel = (req.dst_mode == oag_pkg::OAG_AM_IMM_REL)
        || (req.dst_mode == oag_pkg::OAG_AM_REG_REL);
    assign src_mem = src_ix || src_rel;
    assign dst_mem = dst_ix || dst_rel;

    // choose the index pair and any relative offset
    always_comb
    begin
        pair_sel = req.idx_sel;
        rel_offset = 8'h00;
        rel_en = 1'b0;
        if ((req.src_mode == oag_pkg::OAG_AM_IMM_REL)
            || (req.dst_mode == oag_pkg::OAG_AM_IMM_REL))
        begin
            pair_sel = oag_pkg::OAG_IMM_REL_PAIR; // see [RL6]
            rel_offset = req.imm;
            rel_en = 1'b1;
        end
        else if ((req.src_mode == oag_pkg::OAG_AM_REG_REL)
            || (req.dst_mode == oag_pkg::OAG_AM_REG_REL))
        begin
            rel_offset = acc_sel; // see [RL7]
            rel_en = 1'b1;
        end
    end

    assign pair_base = index_r[pair_sel];
    assign calc_mode = rel_en ? oag_pkg::OAG_IM_KEEP : req.idx_mode;

    // index address and update arithmetic
    oag_index_calc #(
        .IDX_W(IDX_W)
    ) u_calc (
        .base(pair_base),
        .mode(calc_mode),
        .offset(rel_offset),
        .offset_en(rel_en),
        .addr(calc_addr),
        .next(calc_next)
    );

    // decode the operand forms into a plan
    always_comb
    begin
        resp_nxt = '0;
        legal = 1'b0;
        resp_nxt.valid = req.valid;
        resp_nxt.src_reg = req.src_reg;
        resp_nxt.dst_reg = req.dst_reg;
        resp_nxt.operand_b = acc_sel;
        case (req.op)
            oag_pkg::OAG_OP_MOVE:
            begin
                // one byte per move, five kinds of transfer
                if (req.src_mode == oag_pkg::OAG_AM_REG
                    && req.dst_mode == oag_pkg::OAG_AM_REG)
                begin
                    legal = 1'b1;
                    resp_nxt.xfer = oag_pkg::OAG_XF_REG_REG; // see [RL9]
                end
                else if (src_mem && req.dst_mode == oag_pkg::OAG_AM_REG)
                begin
                    legal = (req.src_mode != oag_pkg::OAG_AM_IMM_REL)
                        || (req.dst_reg <= oag_pkg::OAG_LIMITED_LAST); // see [RL15]
                    resp_nxt.xfer = oag_pkg::OAG_XF_MEM_REG; // see [RL9]
                end
                else if (req.src_mode == oag_pkg::OAG_AM_REG && dst_mem)
                begin
                    legal = (req.dst_mode != oag_pkg::OAG_AM_IMM_REL)
                        || (req.src_reg <= oag_pkg::OAG_LIMITED_LAST); // see [RL15]
                    resp_nxt.xfer = oag_pkg::OAG_XF_REG_MEM; // see [RL9]
                end
                else if (req.src_mode == oag_pkg::OAG_AM_IMM
                    && req.dst_mode == oag_pkg::OAG_AM_REG)
                begin
                    legal = (req.dst_reg <= oag_pkg::OAG_LIMITED_LAST); // see [RL10]
                    resp_nxt.xfer = oag_pkg::OAG_XF_IMEM_REG;
                end
                else if (req.src_mode == oag_pkg::OAG_AM_IMM && dst_ix)
                begin
                    legal = (req.idx_mode == oag_pkg::OAG_IM_KEEP); // see [RL10]
                    resp_nxt.xfer = oag_pkg::OAG_XF_IMEM_MEM;
                end
                if (req.src_mode == oag_pkg::OAG_AM_IMM)
                begin
                    resp_nxt.operand_b = req.imm;
                end
            end
            oag_pkg::OAG_OP_ADD,
            oag_pkg::OAG_OP_SUB:
            begin
                resp_nxt.alu = (req.op == oag_pkg::OAG_OP_ADD)
                    ? oag_pkg::OAG_ALU_ADD : oag_pkg::OAG_ALU_SUB; // see [RL11]
                if (req.src_mode == oag_pkg::OAG_AM_IMM)
                begin
                    // one limited register is both source and destination
                    legal = (req.dst_mode == oag_pkg::OAG_AM_REG)
                        && (req.dst_reg <= oag_pkg::OAG_LIMITED_LAST); // see [RL14]
                    resp_nxt.form = oag_pkg::OAG_FORM_IMM;
                    resp_nxt.src_reg = req.dst_reg; // see [RL14]
                    resp_nxt.operand_b = req.imm;
                end
                else if (req.src_mode == oag_pkg::OAG_AM_REG)
                begin
                    // separate register or indexed destination
                    legal = (req.dst_mode == oag_pkg::OAG_AM_REG) || dst_ix; // see [RL12]
                    resp_nxt.form = req.with_carry ? oag_pkg::OAG_FORM_ACC_CARRY
                        : oag_pkg::OAG_FORM_ACC; // see [RL11]
                end
                resp_nxt.xfer = dst_ix ? oag_pkg::OAG_XF_REG_MEM : oag_pkg::OAG_XF_REG_REG;
            end
            oag_pkg::OAG_OP_LONG_JUMP:
            begin
                // index content goes out as an instruction word address
                legal = src_ix;
                resp_nxt.xfer = oag_pkg::OAG_XF_JUMP;
                resp_nxt.imem_en = legal;
                resp_nxt.imem_addr = calc_addr; // see [RL5]
            end
            default:
            begin
                legal = 1'b0;
            end
        endcase
        // relative modes belong to move alone
        if ((src_rel || dst_rel) && (req.op != oag_pkg::OAG_OP_MOVE))
        begin
            legal = 1'b0; // see [RL8]
        end
        resp_nxt.illegal = req.valid && !legal;
        if (!legal)
        begin
            resp_nxt.xfer = oag_pkg::OAG_XF_NONE;
            resp_nxt.alu = oag_pkg::OAG_ALU_NONE;
            resp_nxt.form = oag_pkg::OAG_FORM_NONE;
            resp_nxt.imem_en = 1'b0;
            resp_nxt.imem_addr = '0;
        end
        else if (req.op != oag_pkg::OAG_OP_LONG_JUMP && (src_mem || dst_mem))
        begin
            resp_nxt.dmem_en = req.valid;
            resp_nxt.dmem_addr = calc_addr; // see [RL4] see [RL5]
            resp_nxt.dst_mem = dst_mem;
        end
        if (!req.valid)
        begin
            resp_nxt = '0;
        end
    end

    // an accepted indexed access writes the updated value back
    assign upd_en = req.valid && !resp_nxt.illegal && !rel_en && (src_ix || dst_ix);
    assign wr_off = 5'(gr_wr.addr - oag_pkg::OAG_IDX_REG_BASE);

    // per-pair next value: mode update, then byte writes from the register file
    generate
        for (genvar p = 0; p < oag_pkg::OAG_PAIRS; p++)
        begin : g_pair
            always_comb
            begin
                index_nxt[p] = index_r[p];
                if (upd_en && pair_sel == 2'(p))
                begin
                    index_nxt[p] = calc_next; // see [RL4] see [RL16]
                end
                if (gr_wr.en && gr_wr.addr >= oag_pkg::OAG_IDX_REG_BASE
                    && gr_wr.addr <= oag_pkg::OAG_IDX_REG_LAST
                    && wr_off[2:1] == 2'(p))
                begin
                    if (wr_off[0])
                    begin
                        index_nxt[p][IDX_W-1:8] = gr_wr.data; // see [RL1] see [RL2]
                    end
                    else
                    begin
                        index_nxt[p][7:0] = gr_wr.data; // see [RL2]
                    end
                end
            end

            // index storage, cleared by reset
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    index_r[p] <= IDX_W'(oag_pkg::OAG_IDX_RST); // see [RL3]
                end
                else
                begin
                    index_r[p] <= index_nxt[p];
                end
            end
        end
    endgenerate

    // operand plan register
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            resp_r <= '0;
        end
        else
        begin
            resp_r <= resp_nxt;
        end
    end

    // outputs straight from flops
    assign resp = resp_r;
    assign index_pair_0 = index_r[0];
    assign index_pair_1 = index_r[1];
    assign index_pair_2 = index_r[2];
    assign index_pair_3 = index_r[3];

endmodule

// >>> testbench/oag_mem_model.sv
/*
 * Memory side of the operand plan: counts accesses.
 * Assumes the plan is sampled on the rising clock edge.
 */
`timescale 1ns/1ns
module oag_mem_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // operand plan from the block
    input wire oag_pkg::oag_resp_t resp,
    // accesses seen so far
    output logic [15:0] access_cnt
);
    // one access per plan
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            access_cnt <= 16'h0000;
        end
        else if (resp.dmem_en || resp.imem_en)
        begin
            access_cnt <= access_cnt + 16'h0001;
        end
    end
endmodule

// >>> testbench/oag_top_sva.sv
/*
 * Checker on the oag_top ports, bound below.
 * Assumes one core clock and the active-low reset.
 */
`timescale 1ns/1ns
module oag_top_sva #(
    parameter int IDX_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // inputs of the block
    input wire oag_pkg::oag_req_t req,
    input wire logic [7:0] acc_main,
    input wire logic [7:0] acc_alt,
    input wire logic alt_bank_active,
    input wire oag_pkg::oag_gr_wr_t gr_wr,
    // outputs of the block
    input wire oag_pkg::oag_resp_t resp,
    input wire logic [IDX_W-1:0] index_pair_0,
    input wire logic [IDX_W-1:0] index_pair_1,
    input wire logic [IDX_W-1:0] index_pair_2,
    input wire logic [IDX_W-1:0] index_pair_3
);
    logic [IDX_W-1:0] pairs [4];
    logic [IDX_W-1:0] sel_pair;
    logic [7:0] acc_sel;
    logic [4:0] wr_off;
    logic mv_st;
    logic rel_mode;

    // selected pair, active accumulator and request shapes
    always_comb
    begin
        pairs = '{index_pair_0, index_pair_1, index_pair_2, index_pair_3};
        sel_pair = pairs[req.idx_sel];
        acc_sel = alt_bank_active ? acc_alt : acc_main;
        wr_off = gr_wr.addr - 5'h0C;
        mv_st = req.valid && req.op == oag_pkg::OAG_OP_MOVE && !gr_wr.en
            && req.src_mode == oag_pkg::OAG_AM_REG && req.dst_mode == oag_pkg::OAG_AM_INDEXED;
        rel_mode = req.src_mode >= oag_pkg::OAG_AM_IMM_REL
            || req.dst_mode >= oag_pkg::OAG_AM_IMM_REL;
    end

    // one clock domain for every check
    default clocking dflt @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    chk_answer_next: assert property (req.valid |=> resp.valid)
        else $error("no plan after request");
    chk_post_inc: assert property (
        mv_st && req.idx_mode == oag_pkg::OAG_IM_POST_INC |=> resp.dmem_addr == $past(sel_pair)
        && pairs[$past(req.idx_sel)] == $past(sel_pair) + 1'b1)
        else $error("post-increment wrong");
    chk_pre_inc: assert property (
        mv_st && req.idx_mode == oag_pkg::OAG_IM_PRE_INC
        |=> resp.dmem_addr == $past(sel_pair) + 1'b1
        && pairs[$past(req.idx_sel)] == $past(sel_pair) + 1'b1)
        else $error("pre-increment wrong");
    chk_imm_rel: assert property (
        req.valid && req.op == oag_pkg::OAG_OP_MOVE && req.dst_mode == oag_pkg::OAG_AM_IMM_REL
        && req.src_mode == oag_pkg::OAG_AM_REG && req.src_reg <= 5'h0F
        |=> resp.dmem_en && resp.dmem_addr == $past(index_pair_3) + $past(req.imm))
        else $error("immediate-relative wrong");
    chk_reg_rel: assert property (
        req.valid && req.op == oag_pkg::OAG_OP_MOVE && req.src_mode == oag_pkg::OAG_AM_REG_REL
        && req.dst_mode == oag_pkg::OAG_AM_REG
        |=> resp.dmem_en && resp.dmem_addr == $past(sel_pair) + $past(acc_sel))
        else $error("register-relative wrong");
    chk_rel_move_only: assert property (
        req.valid && req.op != oag_pkg::OAG_OP_MOVE && rel_mode
        |=> resp.illegal && !resp.dmem_en && !resp.imem_en)
        else $error("relative mode outside move");
    chk_reset_clear: assert property (
        disable iff (1'b0) !arst_n
        |-> {index_pair_0, index_pair_1, index_pair_2, index_pair_3} == '0)
        else $error("pair not clear in reset");
    chk_wr_byte: assert property (
        gr_wr.en && !req.valid && gr_wr.addr >= 5'h0C && gr_wr.addr <= 5'h13
        |=> ($past(wr_off[0]) ? pairs[$past(wr_off[2:1])][15:8] : pairs[$past(wr_off[2:1])][7:0])
        == $past(gr_wr.data))
        else $error("write in wrong pair byte");
    chk_jump_word: assert property (
        req.valid && req.op == oag_pkg::OAG_OP_LONG_JUMP && req.src_mode == oag_pkg::OAG_AM_INDEXED
        && req.idx_mode != oag_pkg::OAG_IM_PRE_INC
        |=> resp.imem_en && !resp.dmem_en && resp.imem_addr == $past(sel_pair))
        else $error("long jump wrong");
    chk_imm_arith: assert property (
        req.valid && req.op == oag_pkg::OAG_OP_ADD && req.src_mode == oag_pkg::OAG_AM_IMM
        && req.dst_mode == oag_pkg::OAG_AM_REG && req.dst_reg <= 5'h0F
        |=> resp.alu == oag_pkg::OAG_ALU_ADD && resp.form == oag_pkg::OAG_FORM_IMM
        && resp.operand_b == $past(req.imm) && resp.src_reg == resp.dst_reg)
        else $error("immediate add wrong");
endmodule

bind oag_top oag_top_sva #(.IDX_W(IDX_W)) u_sva (.*);

// >>> testbench/tb_top.sv
/*
 * Self-checking bench for oag_top, one task per scenario.
 * Assumes package, design, checker and memory model compiled first.
 */
`timescale 1ns/1ns
module tb_top;
    logic core_clk;
    logic arst_n;
    oag_pkg::oag_req_t req;
    logic [7:0] acc_main;
    logic [7:0] acc_alt;
    logic alt_bank_active;
    oag_pkg::oag_gr_wr_t gr_wr;
    oag_pkg::oag_resp_t resp;
    wire [3:0][15:0] pr;
    logic [15:0] acc_cnt;
    int num_errors;
    int comparisons;

    // block and memory model
    oag_top u_dut (.*, .index_pair_0(pr[0]), .index_pair_1(pr[1]), .index_pair_2(pr[2]),
        .index_pair_3(pr[3]));
    oag_mem_model u_mem (.*, .access_cnt(acc_cnt));

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic final_report;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // request from raw codes: op, source mode, destination mode, pair, index mode
    function automatic oag_pkg::oag_req_t mk(input logic [2:0] op, input logic [2:0] sm,
        input logic [2:0] dm, input logic [1:0] sel, input logic [1:0] im, input logic [7:0] n,
        input logic [4:0] dr);
        mk = '{1'b1, oag_pkg::oag_op_t'(op), oag_pkg::oag_amode_t'(sm),
            oag_pkg::oag_amode_t'(dm), sel, oag_pkg::oag_imode_t'(im), n, 5'h05, dr, 1'b0};
    endfunction

    // hold a request over one edge; the plan is readable afterwards
    task automatic issue(input oag_pkg::oag_req_t r);
        req = r;
        @(posedge core_clk);
        #2;
    endtask

    // drop the request for one edge
    task automatic idle;
        req.valid = 1'b0;
        @(posedge core_clk);
        #2;
    endtask

    // load both bytes of one pair through the register write port
    task automatic setpair(input logic [1:0] p, input logic [15:0] v);
        gr_wr = '{1'b1, 5'h0C + {2'b00, p, 1'b0}, v[7:0]};
        @(posedge core_clk);
        #2 gr_wr = '{1'b1, 5'h0D + {2'b00, p, 1'b0}, v[15:8]};
        @(posedge core_clk);
        #2 gr_wr.en = 1'b0;
        @(posedge core_clk);
        #2;
    endtask

    // reset value and byte placement of every pair
    task automatic s_pairs;
        for (int p = 0; p < 4; p++)
        begin
            chk(pr[p], 16'h0000);
            setpair(2'(p), {4'hA, 2'b00, 2'(p), 4'h5, 2'b00, 2'(p)});
            chk(pr[p], {4'hA, 2'b00, 2'(p), 4'h5, 2'b00, 2'(p)});
        end
    endtask

    // all four index modes from the top of the range, then two post increments
    task automatic s_modes;
        logic [15:0] ea [4] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000};
        logic [15:0] nv [4] = '{16'hFFFF, 16'hFFFE, 16'h0000, 16'h0000};
        for (int i = 0; i < 4; i++)
        begin
            setpair(2'h1, 16'hFFFF);
            issue(mk(3'h0, 3'h0, 3'h2, 2'h1, 2'(i), 8'h00, 5'h00));
            chk(resp.dmem_addr, ea[i]);
            chk(pr[1], nv[i]);
            chk({resp.xfer, resp.dst_mem}, {oag_pkg::OAG_XF_REG_MEM, 1'b1});
            idle;
        end
        repeat (2) issue(mk(3'h0, 3'h0, 3'h2, 2'h1, 2'h2, 8'h00, 5'h00));
        chk(resp.dmem_addr, 16'h0001);
        chk(pr[1], 16'h0002);
        idle;
    endtask

    // relative modes: carry dropped, bank picks the accumulator, pairs kept
    task automatic s_rel;
        setpair(2'h3, 16'hFFF0);
        setpair(2'h2, 16'h1234);
        acc_main = 8'h11;
        acc_alt = 8'h85;
        alt_bank_active = 1'b1;
        issue(mk(3'h0, 3'h0, 3'h3, 2'h0, 2'h0, 8'h20, 5'h00));
        chk(resp.dmem_addr, 16'h0010);
        issue(mk(3'h0, 3'h4, 3'h0, 2'h2, 2'h0, 8'h00, 5'h01));
        chk(resp.dmem_addr, 16'h12B9);
        chk(resp.xfer, oag_pkg::OAG_XF_MEM_REG);
        alt_bank_active = 1'b0;
        issue(mk(3'h0, 3'h4, 3'h0, 2'h2, 2'h0, 8'h00, 5'h01));
        chk(resp.dmem_addr, 16'h1245);
        idle;
        chk(pr[3], 16'hFFF0);
        chk(pr[2], 16'h1234);
    endtask

    // refused forms give no access and leave pair 0 alone
    task automatic s_illegal;
        oag_pkg::oag_req_t q [5];
        logic [15:0] c0;
        q[0] = mk(3'h1, 3'h0, 3'h4, 2'h0, 2'h0, 8'h00, 5'h01);
        q[1] = mk(3'h2, 3'h3, 3'h0, 2'h0, 2'h0, 8'h00, 5'h01);
        q[2] = mk(3'h0, 3'h1, 3'h0, 2'h0, 2'h0, 8'h12, 5'h10);
        q[3] = mk(3'h0, 3'h1, 3'h2, 2'h0, 2'h2, 8'h12, 5'h00);
        q[4] = mk(3'h2, 3'h1, 3'h0, 2'h0, 2'h0, 8'h01, 5'h14);
        c0 = acc_cnt;
        for (int i = 0; i < 5; i++)
        begin
            issue(q[i]);
            chk({resp.valid, resp.illegal, resp.dmem_en, resp.imem_en, resp.xfer, resp.alu},
                9'h180);
        end
        idle;
        chk(acc_cnt, c0);
        chk(pr[0], 16'hA050);
    endtask

    // the five move kinds, back to back
    task automatic s_moves;
        oag_pkg::oag_req_t q [5];
        logic [2:0] xf [5] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5};
        q[0] = mk(3'h0, 3'h0, 3'h0, 2'h0, 2'h0, 8'h00, 5'h1F);
        q[1] = mk(3'h0, 3'h0, 3'h2, 2'h2, 2'h0, 8'h00, 5'h00);
        q[2] = mk(3'h0, 3'h2, 3'h0, 2'h2, 2'h0, 8'h00, 5'h1F);
        q[3] = mk(3'h0, 3'h1, 3'h0, 2'h0, 2'h0, 8'h5A, 5'h0F);
        q[4] = mk(3'h0, 3'h1, 3'h2, 2'h2, 2'h0, 8'h5A, 5'h00);
        for (int i = 0; i < 5; i++)
        begin
            issue(q[i]);
            chk({resp.illegal, resp.xfer}, {1'b0, xf[i]});
        end
        idle;
    endtask

    // accumulator, accumulator with carry and immediate forms
    task automatic s_arith;
        oag_pkg::oag_req_t r;
        setpair(2'h1, 16'h4321);
        alt_bank_active = 1'b1;
        issue(mk(3'h1, 3'h0, 3'h0, 2'h0, 2'h0, 8'h00, 5'h07));
        chk({resp.alu, resp.form, resp.xfer, resp.dst_reg}, 12'h527);
        chk(resp.operand_b, 8'h85);
        r = mk(3'h2, 3'h0, 3'h2, 2'h1, 2'h0, 8'h00, 5'h00);
        r.with_carry = 1'b1;
        issue(r);
        chk({resp.alu, resp.form, resp.xfer, resp.dst_mem}, 8'hA7);
        chk(resp.dmem_addr, 16'h4321);
        issue(mk(3'h1, 3'h1, 3'h0, 2'h0, 2'h0, 8'h7F, 5'h09));
        chk({resp.alu, resp.form, resp.src_reg, resp.dst_reg}, {4'h7, 5'h09, 5'h09});
        chk(resp.operand_b, 8'h7F);
        idle;
    endtask

    // long jump takes a word address from a post-incremented pair
    task automatic s_jump;
        setpair(2'h0, 16'h0FFF);
        issue(mk(3'h3, 3'h2, 3'h0, 2'h0, 2'h2, 8'h00, 5'h00));
        chk({resp.imem_en, resp.dmem_en, resp.xfer}, 5'h16);
        chk(resp.imem_addr, 16'h0FFF);
        chk(pr[0], 16'h1000);
        idle;
    endtask

    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // cut a hang short
    initial
    begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        final_report;
    end

    // reset, then every scenario
    initial
    begin
        arst_n = 1'b0;
        req = '0;
        gr_wr = '0;
        acc_main = 8'h00;
        acc_alt = 8'h00;
        alt_bank_active = 1'b0;
        num_errors = 0;
        comparisons = 0;
        repeat (10) @(posedge core_clk);
        #2 arst_n = 1'b1;
        s_pairs;
        s_modes;
        s_rel;
        s_illegal;
        s_moves;
        s_arith;
        s_jump;
        final_report;
    end
endmodule
